// ==== rtl/aux_entry_if.sv ====
// Carrier between the entry controller and its line-width counter.
// Assumes both ends run on the same clock.
`include "aux_entry_map.svh"

interface aux_entry_if;
    logic                   lineLevel;   // Synchronised line level
    logic                   lineChange;  // One-cycle pulse on any level change
    aux_entry_pkg::count_type width;     // Cycles since last change, saturating

    modport counter (input lineLevel, output lineChange, output width);
    modport user    (output lineLevel, input lineChange, input width);
endinterface

// ==== rtl/aux_entry_map.svh ====
// Timing and encoding constants for the auxiliary-pulse Manchester entry logic.
// Assumes a 10 MHz system clock; all counts are in clk cycles unless noted.
`ifndef AUX_ENTRY_MAP_SVH
`define AUX_ENTRY_MAP_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define AUX_CLK_HZ              10000000
`define AUX_CLK_PERIOD_NS       100

// ----------------------------------------------------------------
// Times in their own units
// ----------------------------------------------------------------
`define AUX_GATE_TIME_NS        700
`define AUX_MSGRX_MIN_NS        1400
`define AUX_MSGRX_MAX_US        300
`define AUX_PWM_HOLD_PERIODS    2
`define AUX_SENT_HOLD_TICKS     30
`define AUX_SYNC_HOLD_TICKS     50

// ----------------------------------------------------------------
// Derived cycle counts (least rounds up, longest rounds down)
// ----------------------------------------------------------------
`define AUX_GATE_CYCLES  \
    ((`AUX_GATE_TIME_NS + `AUX_CLK_PERIOD_NS - 1) / `AUX_CLK_PERIOD_NS)
`define AUX_MSGRX_CYCLES ((`AUX_MSGRX_MAX_US * 1000) / `AUX_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Defaults and widths
// ----------------------------------------------------------------
`define AUX_TICK_CYCLES_DEF     30
`define AUX_CNT_W               18
`define AUX_STATE_W             6

`endif

// ==== rtl/aux_entry_pkg.sv ====
// Types shared by the auxiliary-pulse Manchester entry logic.
// Assumes aux_entry_map.svh is compiled alongside for widths.
`include "aux_entry_map.svh"

package aux_entry_pkg;

    // Normal output protocol selected by configuration
    typedef enum logic [1:0] {
        OUT_PWM   = 2'h0,
        OUT_SENT  = 2'h1,
        OUT_TRIGGERED_SENT = 2'h2,
        OUT_SYNC  = 2'h3    // sync_slot_sent or addressed_sent
    } outMode_type;

    // Entry sequence states, one-hot
    typedef enum logic [`AUX_STATE_W-1:0] {
        ST_NORMAL  = 6'h01,
        ST_HOLD    = 6'h02,
        ST_RELEASE = 6'h04,
        ST_LOWGATE = 6'h08,
        ST_MANCH   = 6'h10,
        ST_IGNORE  = 6'h20
    } entryState_type;

    typedef logic [`AUX_CNT_W-1:0] count_type;

endpackage

// ==== rtl/aux_pulse_manchester_entry.sv ====
// Auxiliary-pulse entry into Manchester communication on the shared output line.
// Assumes the normal output generator supplies its low-drive request and the
// SENT frame window, and a Manchester receiver reports the end of a session.
`include "aux_entry_map.svh"

module aux_pulse_manchester_entry #(
    parameter int TICK_CYCLES = `AUX_TICK_CYCLES_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        lineIn,
    input  wire logic [1:0]  outMode,
    input  wire logic [15:0] pwmPeriodCycles,
    input  wire logic        frameWindow,
    input  wire logic        normalDriveLow,
    input  wire logic        manchDone,
    output logic             lineOut,
    output logic             lineOe,
    output logic             manchMode,
    output logic             entryPulse,
    output logic             abortPulse
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    aux_entry_if lnk ();

    logic                         lineMeta_ff;
    logic                         lineSync_ff;
    aux_entry_pkg::entryState_type state_ff;
    aux_entry_pkg::entryState_type nxt_state;
    aux_entry_pkg::outMode_type   mode;
    aux_entry_pkg::count_type     holdTarget;
    aux_entry_pkg::count_type     timeout_ff;
    logic                         timeoutRun_ff;
    logic                         ownLow_ff;
    logic                         lineOe_ff;
    logic                         lineOut_ff;
    logic                         manchMode_ff;
    logic                         entryPulse_ff;
    logic                         abortPulse_ff;
    logic                         lineFell;
    logic                         lineRose;
    logic                         startOk;
    logic                         holdMet;
    logic                         gateMet;
    logic                         timedOut;

    localparam aux_entry_pkg::count_type GATE_CYC  = `AUX_CNT_W'(`AUX_GATE_CYCLES);
    localparam aux_entry_pkg::count_type MSGRX_CYC = `AUX_CNT_W'(`AUX_MSGRX_CYCLES);
    localparam aux_entry_pkg::count_type SENT_HOLD =
        `AUX_CNT_W'(`AUX_SENT_HOLD_TICKS * TICK_CYCLES);
    localparam aux_entry_pkg::count_type SYNC_HOLD =
        `AUX_CNT_W'(`AUX_SYNC_HOLD_TICKS * TICK_CYCLES);

    assign mode = aux_entry_pkg::outMode_type'(outMode);

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            lineMeta_ff <= 1'b1;
            lineSync_ff <= 1'b1;
        end else begin
            lineMeta_ff <= lineIn;
            lineSync_ff <= lineMeta_ff;
        end
    end

    assign lnk.lineLevel = lineSync_ff;

    // Width of the present line level
    aux_width_counter u_width (
        .clk (clk),
        .rst (rst),
        .lnk (lnk)
    );

    assign lineFell = lnk.lineChange & ~lnk.lineLevel;
    assign lineRose = lnk.lineChange &  lnk.lineLevel;

    // ----------------------------------------------------------------
    // Entry qualification
    // ----------------------------------------------------------------
    // Minimum hold per output protocol
    always_comb begin
        case (mode)
            aux_entry_pkg::OUT_PWM:
                holdTarget = `AUX_CNT_W'({pwmPeriodCycles, 1'b0});
            aux_entry_pkg::OUT_SENT,
            aux_entry_pkg::OUT_TRIGGERED_SENT:
                holdTarget = SENT_HOLD;
            aux_entry_pkg::OUT_SYNC:
                holdTarget = SYNC_HOLD;
            default:
                holdTarget = SENT_HOLD;
        endcase
    end

    // A low not caused by our own drive, allowed by the protocol's window
    always_comb begin
        case (mode)
            aux_entry_pkg::OUT_PWM:   startOk = 1'b1;
            aux_entry_pkg::OUT_SENT,
            aux_entry_pkg::OUT_TRIGGERED_SENT: startOk = frameWindow;
            aux_entry_pkg::OUT_SYNC:  startOk = 1'b1;
            default:                  startOk = 1'b0;
        endcase
    end

    // Width counter holds the length of the level that just ended at a change
    assign holdMet  = (lnk.width >= holdTarget);
    // Gate floor only, so every bit rate in the allowed range passes
    assign gateMet  = (lnk.width >= GATE_CYC);
    assign timedOut = timeoutRun_ff & (timeout_ff >= MSGRX_CYC);

    // ----------------------------------------------------------------
    // Entry sequence
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            aux_entry_pkg::ST_NORMAL: begin
                if (lineFell && !ownLow_ff) begin
                    nxt_state = startOk ? aux_entry_pkg::ST_HOLD
                                        : aux_entry_pkg::ST_IGNORE;
                end
            end
            aux_entry_pkg::ST_IGNORE: begin
                if (lineRose) begin
                    nxt_state = aux_entry_pkg::ST_NORMAL;
                end
            end
            aux_entry_pkg::ST_HOLD: begin
                if (lineRose) begin
                    nxt_state = holdMet ? aux_entry_pkg::ST_RELEASE
                                        : aux_entry_pkg::ST_NORMAL;
                end
            end
            aux_entry_pkg::ST_RELEASE: begin
                if (timedOut) begin
                    nxt_state = aux_entry_pkg::ST_NORMAL;
                end else if (lineFell) begin
                    // Release shorter than the gate time is a glitch
                    nxt_state = gateMet ? aux_entry_pkg::ST_LOWGATE
                                        : aux_entry_pkg::ST_NORMAL;
                end
            end
            aux_entry_pkg::ST_LOWGATE: begin
                if (timedOut) begin
                    nxt_state = aux_entry_pkg::ST_NORMAL;
                end else if (lineRose) begin
                    // First rising edge of the access code, mid-bit of a leading zero
                    nxt_state = gateMet ? aux_entry_pkg::ST_MANCH
                                        : aux_entry_pkg::ST_NORMAL;
                end
            end
            aux_entry_pkg::ST_MANCH: begin
                if (manchDone) begin
                    nxt_state = aux_entry_pkg::ST_NORMAL;
                end
            end
            default: begin
                nxt_state = aux_entry_pkg::ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= aux_entry_pkg::ST_NORMAL;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Access code timeout, started at the end of the hold
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            timeoutRun_ff <= 1'b0;
            timeout_ff    <= '0;
        end else if (state_ff == aux_entry_pkg::ST_HOLD && lineRose && holdMet) begin
            timeoutRun_ff <= 1'b1;
            timeout_ff    <= '0;
        end else if (nxt_state == aux_entry_pkg::ST_RELEASE
                  || nxt_state == aux_entry_pkg::ST_LOWGATE) begin
            timeout_ff    <= timeout_ff + `AUX_CNT_W'(1);
        end else begin
            timeoutRun_ff <= 1'b0;
            timeout_ff    <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Line drive: normal output only while no entry is under way
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ownLow_ff  <= 1'b0;
            lineOe_ff  <= 1'b0;
            lineOut_ff <= 1'b0;
        end else begin
            ownLow_ff  <= normalDriveLow && nxt_state == aux_entry_pkg::ST_NORMAL;
            lineOe_ff  <= normalDriveLow && nxt_state == aux_entry_pkg::ST_NORMAL;
            lineOut_ff <= 1'b0;   // Open drain: only ever pulls low
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            manchMode_ff  <= 1'b0;
            entryPulse_ff <= 1'b0;
            abortPulse_ff <= 1'b0;
        end else begin
            manchMode_ff  <= (nxt_state == aux_entry_pkg::ST_MANCH);
            entryPulse_ff <= (nxt_state == aux_entry_pkg::ST_MANCH)
                          && (state_ff != aux_entry_pkg::ST_MANCH);
            abortPulse_ff <= timedOut && nxt_state == aux_entry_pkg::ST_NORMAL;
        end
    end

    assign lineOut    = lineOut_ff;
    assign lineOe     = lineOe_ff;
    assign manchMode  = manchMode_ff;
    assign entryPulse = entryPulse_ff;
    assign abortPulse = abortPulse_ff;

endmodule

// ==== rtl/aux_width_counter.sv ====
// Measures how long the shared line has held its present level.
// Assumes lineLevel is already synchronised to clk.
`include "aux_entry_map.svh"

module aux_width_counter (
    input  wire logic        clk,
    input  wire logic        rst,
    aux_entry_if.counter     lnk
);

    logic                      lastLevel_ff;
    aux_entry_pkg::count_type  width_ff;

    // ----------------------------------------------------------------
    // Edge detection on the synchronised level
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            lastLevel_ff <= 1'b1;
        end else begin
            lastLevel_ff <= lnk.lineLevel;
        end
    end

    assign lnk.lineChange = lnk.lineLevel ^ lastLevel_ff;

    // Width counter restarts on every change, saturates at full scale
    always_ff @(posedge clk) begin
        if (rst) begin
            width_ff <= '0;
        end else if (lnk.lineChange) begin
            width_ff <= `AUX_CNT_W'(1);
        end else if (width_ff != {`AUX_CNT_W{1'b1}}) begin
            width_ff <= width_ff + `AUX_CNT_W'(1);
        end
    end

    assign lnk.width = width_ff;

endmodule

// ==== sim/aux_controller_model.sv ====
// External programming controller on the shared open-drain line.
// Assumes the bench calls run right after a rising clock edge.
module aux_controller_model (
    input wire logic clk,
    output logic     pullLow
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pullLow = 1'h0;
    // Hold one level for a number of cycles, changed 1 ns after the edge
    task automatic drive(input logic v, input int n);
        #1 pullLow = v;
        repeat (n) @(posedge clk);
    endtask
    // Hold pulse, release, low gate, then first rising code edge
    task automatic run(input int hold, input int rel, input int low, input bit rise);
        @(posedge clk);
        drive(1'h1, hold);
        drive(1'h0, rel);
        drive(1'h1, low);
        if (rise) begin
            drive(1'h0, 20);
        end
    endtask
    // Let the pull-up take the line
    task automatic release_line();
        @(posedge clk);
        drive(1'h0, 1);
    endtask
endmodule

// ==== sim/aux_pulse_manchester_entry_checker.sv ====
// Port assertions for the auxiliary-pulse Manchester entry block.
// Assumes one clock domain with a synchronous active-high reset.
module aux_pulse_manchester_entry_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        lineIn,
    input wire logic        normalDriveLow,
    input wire logic        manchDone,
    input wire logic        lineOut,
    input wire logic        lineOe,
    input wire logic        manchMode,
    input wire logic        entryPulse,
    input wire logic        abortPulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Entry, session and abort relations
    // ------------------------------------------------------------
    AST_ENTRY_SETS_MODE: assert property (
        entryPulse |-> manchMode && !$past(manchMode))
        else $error("entry pulse without fresh session");
    AST_ENTRY_ONE_CYCLE: assert property (
        entryPulse |=> !entryPulse)
        else $error("entry pulse longer than one cycle");
    AST_ENTRY_AFTER_RISE: assert property (
        entryPulse |-> $past(lineIn, 2) && $past(lineIn))
        else $error("entry without a rising code edge");
    AST_MODE_FROM_ENTRY: assert property (
        $rose(manchMode) |-> entryPulse)
        else $error("session began without entry pulse");
    AST_MODE_STANDS: assert property (
        manchMode && !manchDone |=> manchMode)
        else $error("session dropped before done");
    AST_MODE_ENDS: assert property (
        manchMode && manchDone |-> ##[1:2] !manchMode)
        else $error("session kept after done");
    AST_NO_DRIVE_IN_MODE: assert property (
        manchMode |-> !lineOe)
        else $error("line driven during session");
    AST_ABORT_ONE_CYCLE: assert property (
        abortPulse |=> !abortPulse && !manchMode)
        else $error("abort pulse too long or session after abort");
    AST_ABORT_NOT_ENTRY: assert property (
        abortPulse |-> !entryPulse && !manchMode)
        else $error("abort together with entry");
    AST_OE_FOLLOWS: assert property (
        $rose(lineOe) |-> $past(normalDriveLow) && !manchMode)
        else $error("line pulled without normal request");
    // Open drain: the pin value is low so the pull-up alone releases the line
    AST_LINE_OUT_LOW: assert property (
        lineOut == 1'b0)
        else $error("open-drain output value not low");
endmodule

// ==== sim/aux_pulse_manchester_entry_tb_top.sv ====
// Self-checking bench for the auxiliary-pulse Manchester entry block.
// Assumes a pull-up on the shared line and TICK_CYCLES set to 1.
module aux_pulse_manchester_entry_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0, rst = 1'h1, frameWindow = 1'h0, manchDone = 1'h0;
    logic normalDriveLow = 1'h0;
    logic [1:0]  outMode = 2'h0;
    logic [15:0] pwmPeriodCycles = 16'h0014;
    logic lineOut, lineOe, manchMode, entryPulse, abortPulse, pullLow;
    wire  lineLevel = ~pullLow & ~(lineOe & ~lineOut);
    int   failures = 0, total_checks = 0, entryCnt = 0, abortCnt = 0, cycles = 0;
    logic [4:0] pwmCnt = 5'h00;
    always #50 clk = ~clk;
    // ------------------------------------------------------------
    // Design, controller model and monitors
    // ------------------------------------------------------------
    aux_pulse_manchester_entry #(.TICK_CYCLES(1)) uut (.clk(clk), .rst(rst),
        .lineIn(lineLevel), .outMode(outMode), .pwmPeriodCycles(pwmPeriodCycles),
        .frameWindow(frameWindow), .normalDriveLow(normalDriveLow), .manchDone(manchDone),
        .lineOut(lineOut), .lineOe(lineOe), .manchMode(manchMode),
        .entryPulse(entryPulse), .abortPulse(abortPulse));
    aux_controller_model ctl (.clk(clk), .pullLow(pullLow));
    // Normal output asks for low 5 of every 20 cycles; counts pulses and cycles
    always @(posedge clk) begin
        pwmCnt <= (pwmCnt == 5'h13) ? 5'h00 : pwmCnt + 5'h01;
        normalDriveLow <= #1 (pwmCnt < 5'h05);
        if (entryPulse === 1'h1) entryCnt <= entryCnt + 1;
        if (abortPulse === 1'h1) abortCnt <= abortCnt + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Compare and helper tasks
    // ------------------------------------------------------------
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic cmp_int(input string nm, input int e, input int g);
        total_checks++;
        if (g != e) begin
            failures++;
            $display("FAIL %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Start while the device is not pulling, then run one entry attempt
    task automatic attempt(input logic [1:0] m, input logic fw, input int hold, input int rel,
                           input bit ok);
        int e0;
        e0 = entryCnt;
        @(posedge clk);
        #1 outMode = m;
        frameWindow = fw;
        @(negedge lineOe);
        repeat (2) @(posedge clk);
        ctl.run(hold, rel, 10, 1'b1);
        cmp_int("entryCount", e0 + int'(ok), entryCnt);
        cmp_bit("manchMode", ok, manchMode);
        #1 manchDone = 1'h1;
        @(posedge clk);
        #1 manchDone = 1'h0;
        repeat (3) @(posedge clk);
        cmp_bit("manchModeAfterDone", 1'h0, manchMode);
        repeat (10) @(posedge clk);
    endtask
    // No rising code edge: abort near the timeout, not before
    task automatic timeout_case(input logic [1:0] m);
        int a0;
        int e0;
        a0 = abortCnt;
        e0 = entryCnt;
        @(posedge clk);
        #1 outMode = m;
        frameWindow = 1'h1;
        @(negedge lineOe);
        repeat (2) @(posedge clk);
        ctl.run(44, 10, 10, 1'b0);
        repeat (2900) @(posedge clk);
        cmp_int("abortEarly", a0, abortCnt);
        repeat (200) @(posedge clk);
        cmp_int("abortCount", a0 + 1, abortCnt);
        ctl.release_line();
        repeat (10) @(posedge clk);
        cmp_int("entryAfterAbort", e0, entryCnt);
        cmp_bit("manchModeAfterAbort", 1'h0, manchMode);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_pwm();
        attempt(2'h0, 1'h0, 44, 10, 1'b1);
        attempt(2'h0, 1'h0, 34, 10, 1'b0);
    endtask
    task automatic s_sent();
        for (int m = 1; m < 3; m++) begin
            attempt(2'(m), 1'h0, 34, 10, 1'b0);
            attempt(2'(m), 1'h1, 34, 10, 1'b1);
            attempt(2'(m), 1'h1, 34, 5, 1'b0);
        end
    endtask
    task automatic s_sync();
        attempt(2'h3, 1'h1, 54, 10, 1'b1);
        attempt(2'h3, 1'h1, 44, 10, 1'b0);
    endtask
    task automatic s_timeout();
        timeout_case(2'h0);
        timeout_case(2'h1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'h0;
        repeat (4) @(posedge clk);
        cmp_bit("manchModeReset", 1'h0, manchMode);
        s_pwm();
        s_sent();
        s_sync();
        s_timeout();
        print_verdict();
    end
endmodule

bind aux_pulse_manchester_entry aux_pulse_manchester_entry_checker chk (.clk(clk),
    .rst(rst), .lineIn(lineIn), .normalDriveLow(normalDriveLow), .manchDone(manchDone),
    .lineOut(lineOut), .lineOe(lineOe), .manchMode(manchMode), .entryPulse(entryPulse),
    .abortPulse(abortPulse));
